// File: rtl/ddr_sram_pkg.sv
// Shared constants, enumerations and carriers of the burst-four DDR SRAM port
package ddr_sram_pkg;

	// ==========================================================================
	// Burst shape
	localparam int BEATS = 4;
	localparam int BEAT_IDX_W = 2;

	// ==========================================================================
	// Delay-locked loop model
	localparam int LOCK_CYCLES_DEF = 1024;

	// ==========================================================================
	// Write side sequencing
	typedef enum logic [1:0] {
		W_IDLE,
		W_BEAT1,
		W_BEAT3
	} wr_state_type;

	// ==========================================================================
	// Output control bits that travel with each data beat
	typedef struct packed {
		logic oe;
		logic valid;
		logic echo_true;
		logic echo_comp;
	} out_ctl_type;

	localparam out_ctl_type CTL_RISE_IDLE = 4'h2;
	localparam out_ctl_type CTL_FALL_IDLE = 4'h1;
	localparam out_ctl_type CTL_BURST = 4'hc;

endpackage : ddr_sram_pkg

// File: rtl/bit_sync2.sv
// Two flip-flop level synchroniser
`timescale 1ns/1ns
module bit_sync2 #(
	parameter int WIDTH = 1
) (
	input wire logic clk,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_q
);

	logic [WIDTH-1:0] meta_q;

	// First stage is read only by the second stage
	always_ff @(posedge clk) begin
		meta_q <= async_in;
		sync_q <= meta_q;
	end

endmodule : bit_sync2

// File: rtl/ddr_out_cell.sv
// Double-data-rate output register built from a rise flop and a fall flop
`timescale 1ns/1ns
module ddr_out_cell #(
	parameter int WIDTH = 1
) (
	input wire logic rise_clk,
	input wire logic fall_clk,
	input wire logic rst_b,
	input wire logic [WIDTH-1:0] rise_d,
	input wire logic [WIDTH-1:0] fall_d,
	output logic [WIDTH-1:0] pin_q
);

	logic [WIDTH-1:0] rise_q;
	logic [WIDTH-1:0] fall_q;

	// Xor encoding lets each edge set the pin without a clock-driven mux
	always_ff @(posedge rise_clk) begin
		if (!rst_b) begin
			rise_q <= '0;
		end else begin
			rise_q <= rise_d ^ fall_q;
		end
	end

	always_ff @(posedge fall_clk) begin
		if (!rst_b) begin
			fall_q <= '0;
		end else begin
			fall_q <= fall_d ^ rise_q;
		end
	end

	assign pin_q = rise_q ^ fall_q;

endmodule : ddr_out_cell

// File: rtl/ddr_burst4_cio_sram_interface.sv
// Common-I/O DDR static memory with fixed four-beat bursts and late write
// Contract
// R1: Address, read and write enables captured only on true input clock rising edge.
// R2: Write beats one, three on true clock; two, four on complementary clock.
// R3: Active-low byte masks sampled with every beat; only unmasked bytes written.
// R4: First write beat one cycle after command; next on following complementary edge.
// R5: Write completes over two cycles, buffered internally before array commit.
// R6: First read beat driven at second true-clock edge after read command.
// R7: Second read beat driven at third complementary edge after the command.
// R8: Read beats one, three on true clock; two, four on complementary clock.
// R9: Every read and write moves exactly four beats.
// R10: Controller issues commands at most every second true-clock cycle.
// R11: Shared data bus; device drives only during read beats.
// R12: Echo clocks leave together with the read data.
// R13: Address and control registered only on rising input clock edges.
// R14: Read-valid output asserted with read data, aligned to echo edges.
// R15: Lock-loop disable low selects one-cycle read latency.
// R16: Address ignored in cycles without load select.
// R17: Read after write returns newest bytes, even from the write buffer.
// R18: Load select low starts burst; read/write select high reads, low writes.
`timescale 1ns/1ns
module ddr_burst4_cio_sram_interface #(
	parameter int ADDR_W = 18,
	parameter int DATA_W = 18,
	parameter int BYTES = 2,
	parameter int LOCK_CYCLES = ddr_sram_pkg::LOCK_CYCLES_DEF
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic link_clk_true,
	input wire logic link_clk_comp,
	input wire logic doff_n,
	input wire logic load_select_n,
	input wire logic read_not_write,
	input wire logic [ADDR_W-1:0] sync_address,
	input wire logic [DATA_W-1:0] dq_in,
	input wire logic [BYTES-1:0] byte_write_mask_n,
	output logic [DATA_W-1:0] dq_out,
	output logic dq_oe,
	output logic read_data_valid,
	output logic echo_clock_true,
	output logic echo_clock_comp,
	output logic dll_locked
);

	// ==========================================================================
	// Derived sizes and elaboration checks
	localparam int BYTE_W = DATA_W / BYTES;
	localparam int DEPTH = 2 ** (ADDR_W + ddr_sram_pkg::BEAT_IDX_W);
	localparam int LOCK_W = $clog2(LOCK_CYCLES + 1);
	localparam int MEM_A_W = ADDR_W + ddr_sram_pkg::BEAT_IDX_W;

	if (BYTES < 1 || DATA_W % BYTES != 0 || ADDR_W < 1 || LOCK_CYCLES < 1) begin : g_bad_cfg
		$error("Unsupported width, byte or lock-count setting");
	end

	// ==========================================================================
	// Reference domain: lock-loop model
	logic doff_ref;
	logic [LOCK_W-1:0] lock_cnt_q;
	logic dll_locked_q;

	bit_sync2 #(.WIDTH(1)) u_doff_sync (
		.clk(ref_clk),
		.async_in(doff_n),
		.sync_q(doff_ref)
	);

	// Disable low holds the loop in reset and drops any lock already gained
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			lock_cnt_q <= '0;
			dll_locked_q <= 1'b0;
		end else if (!doff_ref) begin
			lock_cnt_q <= '0;
			dll_locked_q <= 1'b0;
		end else if (!dll_locked_q) begin
			if (lock_cnt_q == LOCK_W'(LOCK_CYCLES - 1)) begin
				dll_locked_q <= 1'b1;
			end else begin
				lock_cnt_q <= lock_cnt_q + LOCK_W'(1);
			end
		end
	end

	assign dll_locked = dll_locked_q;

	// ==========================================================================
	// Crossing into the link domain
	logic link_rst_b;
	logic lat2_q;

	bit_sync2 #(.WIDTH(2)) u_link_sync (
		.clk(link_clk_true),
		.async_in({rst_b, dll_locked_q}),
		.sync_q({link_rst_b, lat2_q})
	);

	// ==========================================================================
	// Command capture on the true clock
	logic new_read;
	logic new_write;
	logic [ADDR_W-1:0] addr_q;
	logic rd_cmd_q;

	assign new_read = !load_select_n && read_not_write; // R18
	assign new_write = !load_select_n && !read_not_write; // R18

	always_ff @(posedge link_clk_true) begin
		if (!link_rst_b) begin
			addr_q <= '0;
		end else if (!load_select_n) begin
			addr_q <= sync_address; // R1 R13 R16
		end
	end

	always_ff @(posedge link_clk_true) begin
		if (!link_rst_b) begin
			rd_cmd_q <= 1'b0;
		end else begin
			rd_cmd_q <= new_read; // R1
		end
	end

	// ==========================================================================
	// Write buffer
	ddr_sram_pkg::wr_state_type wr_state_q;
	logic commit_q;
	logic [ADDR_W-1:0] cm_addr_q;
	logic [DATA_W-1:0] wd_q [ddr_sram_pkg::BEATS-1];
	logic [BYTES-1:0] wm_q [ddr_sram_pkg::BEATS-1];
	logic [DATA_W-1:0] fall_d_q;
	logic [BYTES-1:0] fall_m_q;
	logic [DATA_W-1:0] cm_d [ddr_sram_pkg::BEATS];
	logic [BYTES-1:0] cm_m [ddr_sram_pkg::BEATS];

	// Even beats land on the complementary clock and wait here for the true clock
	always_ff @(posedge link_clk_comp) begin
		fall_d_q <= dq_in; // R2
		fall_m_q <= byte_write_mask_n; // R3
	end

	// A new write may start in the cycle that captures the previous third beat
	always_ff @(posedge link_clk_true) begin
		if (!link_rst_b) begin
			wr_state_q <= ddr_sram_pkg::W_IDLE;
			commit_q <= 1'b0;
		end else begin
			commit_q <= (wr_state_q == ddr_sram_pkg::W_BEAT3); // R5
			case (wr_state_q)
				ddr_sram_pkg::W_IDLE: begin
					if (new_write) begin
						wr_state_q <= ddr_sram_pkg::W_BEAT1; // R4
					end
				end
				ddr_sram_pkg::W_BEAT1: begin
					wr_state_q <= ddr_sram_pkg::W_BEAT3;
				end
				ddr_sram_pkg::W_BEAT3: begin
					if (new_write) begin
						wr_state_q <= ddr_sram_pkg::W_BEAT1;
					end else begin
						wr_state_q <= ddr_sram_pkg::W_IDLE;
					end
				end
				default: begin
					wr_state_q <= ddr_sram_pkg::W_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge link_clk_true) begin
		if (!link_rst_b) begin
			cm_addr_q <= '0;
			for (int i = 0; i < ddr_sram_pkg::BEATS - 1; i++) begin
				wd_q[i] <= '0;
				wm_q[i] <= '1;
			end
		end else if (wr_state_q == ddr_sram_pkg::W_BEAT1) begin
			wd_q[0] <= dq_in; // R2 R4
			wm_q[0] <= byte_write_mask_n; // R3
		end else if (wr_state_q == ddr_sram_pkg::W_BEAT3) begin
			wd_q[1] <= fall_d_q; // R2
			wm_q[1] <= fall_m_q; // R3
			wd_q[2] <= dq_in; // R2
			wm_q[2] <= byte_write_mask_n; // R3
			cm_addr_q <= addr_q;
		end
	end

	// Fourth beat is still in the complementary capture register at commit time
	always_comb begin
		for (int i = 0; i < ddr_sram_pkg::BEATS - 1; i++) begin
			cm_d[i] = wd_q[i];
			cm_m[i] = wm_q[i];
		end
		cm_d[ddr_sram_pkg::BEATS-1] = fall_d_q;
		cm_m[ddr_sram_pkg::BEATS-1] = fall_m_q;
	end

	// ==========================================================================
	// Array
	logic [DATA_W-1:0] mem [DEPTH];

	always_ff @(posedge link_clk_true) begin
		if (commit_q) begin
			for (int b = 0; b < ddr_sram_pkg::BEATS; b++) begin
				for (int j = 0; j < BYTES; j++) begin
					if (!cm_m[b][j]) begin
						mem[{cm_addr_q, ddr_sram_pkg::BEAT_IDX_W'(b)}][j*BYTE_W +: BYTE_W] <=
							cm_d[b][j*BYTE_W +: BYTE_W]; // R3 R5 R9
					end
				end
			end
		end
	end

	// ==========================================================================
	// Read fetch with forwarding from the pending commit
	logic fwd_hit;
	logic [DATA_W-1:0] fetch [ddr_sram_pkg::BEATS];
	logic [DATA_W-1:0] rd_buf_q [ddr_sram_pkg::BEATS];
	logic [DATA_W-1:0] burst_sel [ddr_sram_pkg::BEATS];

	assign fwd_hit = commit_q && (cm_addr_q == addr_q); // R17

	for (genvar g = 0; g < ddr_sram_pkg::BEATS; g++) begin : g_beat
		logic [MEM_A_W-1:0] rd_idx;
		assign rd_idx = {addr_q, ddr_sram_pkg::BEAT_IDX_W'(g)};
		for (genvar j = 0; j < BYTES; j++) begin : g_lane
			assign fetch[g][j*BYTE_W +: BYTE_W] = (fwd_hit && !cm_m[g][j]) ?
				cm_d[g][j*BYTE_W +: BYTE_W] : mem[rd_idx][j*BYTE_W +: BYTE_W]; // R17
		end
		assign burst_sel[g] = lat2_q ? rd_buf_q[g] : fetch[g]; // R15
	end

	always_ff @(posedge link_clk_true) begin
		if (rd_cmd_q) begin
			rd_buf_q <= fetch;
		end
	end

	// ==========================================================================
	// Read output sequencing
	logic rd_arm_q;
	logic out_start;
	logic out_second_q;
	logic [DATA_W-1:0] hold3_q;
	logic [DATA_W-1:0] hold4_q;
	logic [DATA_W-1:0] fall_data_q;
	ddr_sram_pkg::out_ctl_type fall_ctl_q;
	logic [DATA_W-1:0] rise_data;
	ddr_sram_pkg::out_ctl_type rise_ctl;

	always_ff @(posedge link_clk_true) begin
		if (!link_rst_b) begin
			rd_arm_q <= 1'b0;
		end else begin
			rd_arm_q <= rd_cmd_q && lat2_q;
		end
	end

	// Latency changes are only safe with no read in flight
	assign out_start = lat2_q ? rd_arm_q : rd_cmd_q; // R6 R15

	always_ff @(posedge link_clk_true) begin
		if (!link_rst_b) begin
			out_second_q <= 1'b0;
			hold3_q <= '0;
			hold4_q <= '0;
			fall_data_q <= '0;
			fall_ctl_q <= ddr_sram_pkg::CTL_FALL_IDLE;
		end else begin
			out_second_q <= out_start; // R9
			if (out_start) begin
				fall_data_q <= burst_sel[1]; // R7 R8
				hold3_q <= burst_sel[2];
				hold4_q <= burst_sel[3];
			end else if (out_second_q) begin
				fall_data_q <= hold4_q; // R8
			end else begin
				fall_data_q <= '0;
			end
			if (out_start || out_second_q) begin
				fall_ctl_q <= ddr_sram_pkg::CTL_FALL_IDLE | ddr_sram_pkg::CTL_BURST; // R11 R14
			end else begin
				fall_ctl_q <= ddr_sram_pkg::CTL_FALL_IDLE;
			end
		end
	end

	always_comb begin
		rise_data = '0;
		rise_ctl = ddr_sram_pkg::CTL_RISE_IDLE; // R12
		if (out_start) begin
			rise_data = burst_sel[0]; // R6 R8
			rise_ctl = ddr_sram_pkg::CTL_RISE_IDLE | ddr_sram_pkg::CTL_BURST; // R11 R14
		end else if (out_second_q) begin
			rise_data = hold3_q; // R8
			rise_ctl = ddr_sram_pkg::CTL_RISE_IDLE | ddr_sram_pkg::CTL_BURST;
		end
	end

	// Echo clocks share the data register so their edges match the beats
	ddr_out_cell #(.WIDTH(DATA_W + 4)) u_out_cell (
		.rise_clk(link_clk_true),
		.fall_clk(link_clk_comp),
		.rst_b(link_rst_b),
		.rise_d({rise_data, rise_ctl}),
		.fall_d({fall_data_q, fall_ctl_q}),
		.pin_q({dq_out, dq_oe, read_data_valid, echo_clock_true, echo_clock_comp}) // R12 R14
	);

	// ==========================================================================
	// Checks
	default clocking cb @(posedge link_clk_true); endclocking
	default disable iff (!link_rst_b);

	chk_read_lat_two: assert property (rd_cmd_q && lat2_q |-> !out_start ##1 out_start) // R6
		else $error("Read start not two cycles after command");
	chk_read_lat_one: assert property (rd_cmd_q && !lat2_q |-> out_start ##1 dq_oe && read_data_valid) // R15
		else $error("Read start not one cycle after command");
	chk_burst_four: assert property (out_start |=> out_second_q && !out_start) // R9
		else $error("Read burst not two beat pairs");
	chk_write_commit_two: assert property (new_write |-> ##3 commit_q) // R5
		else $error("Write commit not after two data cycles");
	chk_write_beat_order: assert property (new_write |=> (wr_state_q == ddr_sram_pkg::W_BEAT1)
		##1 (wr_state_q == ddr_sram_pkg::W_BEAT3)) // R4
		else $error("Write beats not captured in order");
	// Sync flops start unknown, so reset-state checks wait for a known link reset
	chk_deselect_addr: assert property (link_rst_b && load_select_n |=> $stable(addr_q)) // R16
		else $error("Address taken while deselected");
	chk_valid_with_oe: assert property (link_rst_b |-> read_data_valid == dq_oe &&
		dq_oe == $past(out_start || out_second_q)) // R14
		else $error("Valid or enable not matching read beats");
	chk_even_beats: assert property (out_start |=> (fall_data_q == $past(burst_sel[1]))
		##1 (fall_data_q == $past(burst_sel[3], 2))) // R7
		else $error("Even read beats out of order");
	chk_byte_commit: assert property (commit_q && !cm_m[0][0] |=>
		mem[{$past(cm_addr_q), ddr_sram_pkg::BEAT_IDX_W'(0)}][BYTE_W-1:0] ==
		$past(cm_d[0][BYTE_W-1:0])) // R3
		else $error("Unmasked byte not written");
	chk_forward_hit: assert property (rd_cmd_q && fwd_hit && !cm_m[0][0] |=>
		rd_buf_q[0][BYTE_W-1:0] == $past(cm_d[0][BYTE_W-1:0])) // R17
		else $error("Read missed buffered write data");

	cov_read_slow: cover property (rd_cmd_q && lat2_q ##2 out_second_q);
	cov_read_fast: cover property (rd_cmd_q && !lat2_q ##1 out_second_q);
	cov_write_pair: cover property (new_write ##2 new_write ##3 commit_q);
	cov_forward: cover property (rd_cmd_q && fwd_hit);

endmodule : ddr_burst4_cio_sram_interface

// File: testbench/sram_ctrl_model.sv
// Behavioural external controller that drives bursts into the SRAM port
`timescale 1ns/1ns
module sram_ctrl_model #(
	parameter int ADDR_W = 4,
	parameter int DATA_W = 18,
	parameter int BYTES = 2
) (
	input wire logic clk_true,
	input wire logic clk_comp,
	output logic load_select_n,
	output logic read_not_write,
	output logic [ADDR_W-1:0] sync_address,
	output logic [DATA_W-1:0] dq_in,
	output logic [BYTES-1:0] byte_write_mask_n,
	input wire logic [DATA_W-1:0] dq_out,
	input wire logic dq_oe,
	input wire logic read_data_valid,
	input wire logic echo_clock_true,
	input wire logic echo_clock_comp
);
	initial begin
		load_select_n = 1'b1;
		read_not_write = 1'b1;
		sync_address = '0;
		dq_in = '0;
		byte_write_mask_n = '1;
	end

	// ================
	// Command slot, held from just after one true edge to just after the next
	task automatic issue(input logic rd, input logic [ADDR_W-1:0] addr);
		@(posedge clk_true);
		#1;
		load_select_n = 1'b0;
		read_not_write = rd;
		sync_address = addr;
		@(posedge clk_true);
		#1;
		load_select_n = 1'b1;
		sync_address = ~addr;
	endtask : issue

	task automatic write_burst(input logic [ADDR_W-1:0] addr, input logic [3:0][DATA_W-1:0] d,
			input logic [3:0][BYTES-1:0] m, output logic ok);
		ok = 1'b1;
		issue(1'b0, addr);
		for (int k = 0; k < 4; k++) begin
			dq_in = d[k];
			byte_write_mask_n = m[k];
			ok = ok & !dq_oe;
			if (k % 2 == 0) @(posedge clk_true);
			else @(posedge clk_comp);
			#1;
		end
		// No pull-up on the bus, so a released line must not keep the last beat
		dq_in = ~dq_in;
		byte_write_mask_n = ~byte_write_mask_n;
	endtask : write_burst

	task automatic read_burst(input logic [ADDR_W-1:0] addr, input int lat,
			output logic [3:0][DATA_W-1:0] d, output logic ok);
		ok = 1'b1;
		issue(1'b1, addr);
		repeat (lat) @(posedge clk_true);
		for (int k = 0; k < 4; k++) begin
			#1;
			d[k] = dq_out;
			ok = ok & dq_oe & read_data_valid;
			ok = ok & (echo_clock_true === !k[0]) & (echo_clock_comp === k[0]);
			if (k % 2 == 0) @(posedge clk_comp);
			else @(posedge clk_true);
		end
		#1;
		ok = ok & !dq_oe & !read_data_valid;
	endtask : read_burst

	task automatic deselect(input int n, input logic [ADDR_W-1:0] addr);
		repeat (n) begin
			@(posedge clk_true);
			#1;
			read_not_write = ~read_not_write;
			sync_address = addr;
			dq_in = ~dq_in;
			byte_write_mask_n = '0;
		end
	endtask : deselect
endmodule : sram_ctrl_model

// File: testbench/ddr_burst4_cio_sram_interface_test.sv
// Self-checking bench for the burst-four DDR SRAM port
`timescale 1ns/1ns
module ddr_burst4_cio_sram_interface_test;
	localparam int AW = 4;
	localparam int DW = 18;
	localparam int NB = 2;

	logic ref_clk = 1'b0;
	logic link_clk_true = 1'b0;
	logic link_clk_comp;
	logic rst_b = 1'b0;
	logic doff_n = 1'b1;
	logic load_select_n;
	logic read_not_write;
	logic [AW-1:0] sync_address;
	logic [DW-1:0] dq_in;
	logic [NB-1:0] byte_write_mask_n;
	logic [DW-1:0] dq_out;
	logic dq_oe;
	logic read_data_valid;
	logic echo_clock_true;
	logic echo_clock_comp;
	logic dll_locked;
	logic [3:0][DW-1:0] stored;
	int mismatches = 0;
	int n_compared = 0;

	always #50 ref_clk = ~ref_clk;
	always #3 link_clk_true = ~link_clk_true;
	assign link_clk_comp = ~link_clk_true;

	ddr_burst4_cio_sram_interface #(.ADDR_W(AW), .DATA_W(DW), .BYTES(NB), .LOCK_CYCLES(4)) u_dut (
		.ref_clk(ref_clk), .rst_b(rst_b), .doff_n(doff_n),
		.link_clk_true(link_clk_true), .link_clk_comp(link_clk_comp),
		.load_select_n(load_select_n), .read_not_write(read_not_write),
		.sync_address(sync_address), .dq_in(dq_in), .byte_write_mask_n(byte_write_mask_n),
		.dq_out(dq_out), .dq_oe(dq_oe), .read_data_valid(read_data_valid),
		.echo_clock_true(echo_clock_true), .echo_clock_comp(echo_clock_comp),
		.dll_locked(dll_locked)
	);

	sram_ctrl_model #(.ADDR_W(AW), .DATA_W(DW), .BYTES(NB)) u_ctrl (
		.clk_true(link_clk_true), .clk_comp(link_clk_comp),
		.load_select_n(load_select_n), .read_not_write(read_not_write),
		.sync_address(sync_address), .dq_in(dq_in), .byte_write_mask_n(byte_write_mask_n),
		.dq_out(dq_out), .dq_oe(dq_oe), .read_data_valid(read_data_valid),
		.echo_clock_true(echo_clock_true), .echo_clock_comp(echo_clock_comp)
	);

	// ================
	// Comparison helpers
	task automatic check(input string what, input logic [DW-1:0] exp, input logic [DW-1:0] got);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic check_burst(input string what, input logic [3:0][DW-1:0] exp,
			input logic [3:0][DW-1:0] got, input logic ok);
		check({what, " strobes"}, 18'h1, {17'h0, ok});
		for (int k = 0; k < 4; k++) check(what, exp[k], got[k]);
	endtask : check_burst

	function automatic logic [DW-1:0] merge(input logic [DW-1:0] old_v,
			input logic [DW-1:0] new_v, input logic [NB-1:0] m);
		logic [DW-1:0] r;
		r = old_v;
		for (int j = 0; j < NB; j++) if (!m[j]) r[j*9+:9] = new_v[j*9+:9];
		return r;
	endfunction : merge

	// Read issued two true edges after the write, while its data is still buffered
	task automatic write_then_read(input logic [3:0][DW-1:0] d, input logic [3:0][NB-1:0] m,
			output logic [3:0][DW-1:0] rd, output logic ok);
		logic wok;
		logic rok;
		fork
			u_ctrl.write_burst(4'h5, d, m, wok);
			begin
				repeat (2) @(posedge link_clk_true);
				u_ctrl.read_burst(4'h5, 2, rd, rok);
			end
		join
		ok = wok & rok;
	endtask : write_then_read

	// ================
	// Scenarios
	task automatic test_lock();
		int n;
		n = 0;
		while (dll_locked !== 1'b1 && n < 50) begin
			@(posedge ref_clk);
			#1;
			n++;
		end
		check("lock flag", 18'h1, {17'h0, dll_locked});
		@(posedge link_clk_true);
		#1;
		check("echo pair", 18'h2, {16'h0, echo_clock_true, echo_clock_comp});
		repeat (4) @(posedge link_clk_true);
	endtask : test_lock

	task automatic test_forward();
		logic [3:0][DW-1:0] d;
		logic [3:0][DW-1:0] rd;
		logic ok;
		d = {18'h3_c3c3, 18'h2_b2b2, 18'h1_a1a1, 18'h0_9090};
		write_then_read(d, '0, rd, ok);
		check_burst("forwarded read", d, rd, ok);
		u_ctrl.read_burst(4'h5, 2, rd, ok);
		check_burst("committed read", d, rd, ok);
		stored = d;
	endtask : test_forward

	task automatic test_masked();
		logic [3:0][DW-1:0] d;
		logic [3:0][DW-1:0] rd;
		logic [3:0][DW-1:0] ex;
		logic [3:0][NB-1:0] m;
		logic ok;
		d = {18'h2_5555, 18'h2_6666, 18'h2_7777, 18'h2_8888};
		m = {2'b00, 2'b01, 2'b10, 2'b11};
		for (int k = 0; k < 4; k++) ex[k] = merge(stored[k], d[k], m[k]);
		write_then_read(d, m, rd, ok);
		check_burst("masked read", ex, rd, ok);
		stored = ex;
	endtask : test_masked

	task automatic test_deselect();
		logic [3:0][DW-1:0] rd;
		logic ok;
		u_ctrl.deselect(6, 4'h5);
		u_ctrl.read_burst(4'h5, 2, rd, ok);
		check_burst("after deselect", stored, rd, ok);
	endtask : test_deselect

	task automatic test_bypass();
		logic [3:0][DW-1:0] rd;
		logic ok;
		@(posedge ref_clk);
		#1;
		doff_n = 1'b0;
		repeat (4) @(posedge ref_clk);
		#1;
		check("lock after bypass", 18'h0, {17'h0, dll_locked});
		u_ctrl.read_burst(4'h5, 1, rd, ok);
		check_burst("one cycle latency", stored, rd, ok);
	endtask : test_bypass

	task automatic final_report();
		$display("Comparisons %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : final_report

	initial begin
		repeat (5) @(posedge ref_clk);
		#1;
		check("reset outputs", 18'h0, {13'h0, dq_oe, read_data_valid, echo_clock_true,
			echo_clock_comp, dll_locked});
		repeat (5) @(posedge ref_clk);
		#1;
		rst_b = 1'b1;
		test_lock();
		test_forward();
		test_masked();
		test_deselect();
		test_bypass();
		final_report();
	end

	// A whole run needs a few microseconds, so this only trips on a hang
	initial begin
		#50000;
		mismatches++;
		final_report();
	end
endmodule : ddr_burst4_cio_sram_interface_test
